// File: design/tsa_pkg.sv
// Package for the temperature sensor alarm core: register map, field layout,
// reset values and timing constants. Assumes a 125 MHz reference clock.
package tsa_pkg;

	// =====================================================================
	// Register bus map, word offsets.
	localparam logic [7:0] TSA_TEMP_OFS = 8'h00;
	localparam logic [7:0] TSA_CFG_OFS = 8'h04;
	localparam logic [7:0] TSA_OTL_OFS = 8'h08;
	localparam logic [7:0] TSA_HYL_OFS = 8'h0c;
	localparam logic [7:0] TSA_STAT_OFS = 8'h10;
	localparam logic [7:0] TSA_MASK_OFS = 8'h14;
	localparam logic [7:0] TSA_SENS_OFS = 8'h18;

	// =====================================================================
	// Configuration field positions and reset values.
	localparam int TSA_CFG_SD_POS = 0;
	localparam int TSA_CFG_INT_POS = 1;
	localparam int TSA_CFG_POL_POS = 2;
	localparam int TSA_CFG_FQ_POS = 3;
	localparam int TSA_CFG_RES_POS = 5;
	localparam logic [7:0] TSA_CFG_RST = 8'h00;
	localparam logic [15:0] TSA_OTL_RST = 16'h5000;
	localparam logic [15:0] TSA_HYL_RST = 16'h4b00;
	localparam logic [15:0] TSA_TEMP_RST = 16'h0000;

	// Status bits: conversion done, alarm asserted.
	localparam int TSA_ST_CONV_POS = 0;
	localparam int TSA_ST_ALM_POS = 1;
	localparam int TSA_ST_W = 2;

	// =====================================================================
	// Timing.
	localparam int TSA_CLK_MHZ = 125;
	localparam int TSA_CONV_9B_MS = 150;
	localparam int TSA_CONV_9B_CYC = TSA_CONV_9B_MS * TSA_CLK_MHZ * 1000;
	localparam int TSA_I2C_MAX_KHZ = 400;
	localparam int TSA_I2C_MIN_HALF_CYC = (TSA_CLK_MHZ * 1000) / (TSA_I2C_MAX_KHZ * 2);

	typedef enum logic [1:0] {TSA_RES_9, TSA_RES_10, TSA_RES_11, TSA_RES_12} tsa_res_t;

endpackage

// File: design/tsa_i2c_slave.sv
// I2C slave for the alarm core: decodes address, pointer and data bytes.
// Assumes SCL and SDA already passed two flip-flops on the reference clock.
`timescale 1ns/100ps
module tsa_i2c_slave
	import tsa_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [2:0] addr_sel_i,
	output logic sda_oe_n_o,
	output logic [7:0] ptr_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output logic wr_first_o,
	output logic rd_o,
	input wire logic [15:0] rdata_i
);

	typedef enum {S_IDLE, S_ADDR, S_AACK, S_WBYTE, S_WACK, S_RBYTE, S_RACK} tsa_i2c_st_t;

	// =====================================================================
	// Edge and condition detection.
	logic scl_q, sda_q, start_c, stop_c, rise_c, fall_c;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end
	assign start_c = scl_i && scl_q && sda_q && !sda_i;
	assign stop_c = scl_i && scl_q && !sda_q && sda_i;
	assign rise_c = scl_i && !scl_q;
	assign fall_c = !scl_i && scl_q;

	// =====================================================================
	// Byte engine.
	tsa_i2c_st_t st_q, st_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
	logic [3:0] cnt_q, cnt_d;
	logic [1:0] nb_q, nb_d;
	logic rnw_q, rnw_d, oe_q, oe_d, wr_d, wr_q, rd_d, rd_q, nack_q, nack_d;
	logic [15:0] rsh_q, rsh_d;

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		nb_d = nb_q;
		rnw_d = rnw_q;
		oe_d = oe_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		nack_d = nack_q;
		rsh_d = rsh_q;
		if (start_c) begin
			st_d = S_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b1;
		end else if (stop_c) begin
			st_d = S_IDLE;
			oe_d = 1'b1;
		end else begin
			case (st_q)
				S_ADDR, S_WBYTE: begin
					if (rise_c) begin
						sh_d = {sh_q[6:0], sda_i};
						cnt_d = cnt_q + 4'h1;
					end else if (fall_c && cnt_q == 4'h8) begin
						cnt_d = 4'h0;
						if (st_q == S_ADDR) begin
							if (sh_q[7:1] == {4'h9, addr_sel_i}) begin
								rnw_d = sh_q[0];
								oe_d = 1'b0;
								nb_d = 2'h0;
								st_d = S_AACK;
							end else begin
								st_d = S_IDLE;
							end
						end else begin
							oe_d = 1'b0;
							st_d = S_WACK;
							if (nb_q == 2'h0) begin
								ptr_d = sh_q;
							end else begin
								wr_d = 1'b1;
							end
						end
					end
				end
				S_AACK, S_WACK: begin
					if (fall_c) begin
						if (st_q == S_WACK && nb_q != 2'h3) begin
							nb_d = nb_q + 2'h1;
						end
						if (rnw_q) begin
							rd_d = 1'b1;
							rsh_d = rdata_i;
							oe_d = rdata_i[15];
							cnt_d = 4'h1;
							st_d = S_RBYTE;
						end else begin
							oe_d = 1'b1;
							st_d = S_WBYTE;
						end
					end
				end
				S_RBYTE: begin
					if (fall_c) begin
						if (cnt_q == 4'h8) begin
							oe_d = 1'b1;
							st_d = S_RACK;
						end else begin
							oe_d = rsh_q[4'd15 - cnt_q];
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				S_RACK: begin
					if (rise_c) begin
						nack_d = sda_i;
					end else if (fall_c) begin
						if (nack_q) begin
							st_d = S_IDLE;
						end else begin
							rsh_d = {rsh_q[7:0], 8'h00};
							oe_d = rsh_q[7];
							cnt_d = 4'h1;
							st_d = S_RBYTE;
						end
					end
				end
				default: st_d = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= S_IDLE;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 4'h0;
			nb_q <= 2'h0;
			rnw_q <= 1'b0;
			oe_q <= 1'b1;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			nack_q <= 1'b0;
			rsh_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			nb_q <= nb_d;
			rnw_q <= rnw_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			nack_q <= nack_d;
			rsh_q <= rsh_d;
		end
	end

	assign sda_oe_n_o = oe_q;
	assign ptr_o = ptr_q;
	assign wr_o = wr_q;
	assign wdata_o = sh_q;
	// The byte count advances only after the acknowledge, so the first data byte sees one.
	assign wr_first_o = (nb_q == 2'h1);
	assign rd_o = rd_q;

endmodule

// File: design/tsa_core.sv
// Top of the temperature sensor alarm core: conversion timing, limits,
// alarm logic, register port and I2C access. Assumes the analog front end
// delivers a 12-bit Celsius code on SENSE_CODE_I in the reference domain.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps

module tsa_core
	import tsa_pkg::*;
#(
	parameter int CONV_CYCLES = TSA_CONV_9B_CYC
) (
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N_O,
	input wire logic ADDR_SELECT_BIT0_I,
	input wire logic ADDR_SELECT_BIT1_I,
	input wire logic ADDR_SELECT_BIT2_I,
	output logic THERMAL_ALARM_OUT_O,
	output logic THERMAL_ALARM_OUT_OE_N_O,
	input wire logic [11:0] SENSE_CODE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	output logic IRQ_O
);

	// =====================================================================
	// Pin synchronisers.
	logic [1:0] scl_s_q, sda_s_q;
	logic [2:0] asel_s1_q, asel_s2_q;
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			scl_s_q <= 2'b11;
			sda_s_q <= 2'b11;
			asel_s1_q <= 3'h0;
			asel_s2_q <= 3'h0;
		end else begin
			scl_s_q <= {scl_s_q[0], SCL_I};
			sda_s_q <= {sda_s_q[0], SDA_I};
			asel_s1_q <= {ADDR_SELECT_BIT2_I, ADDR_SELECT_BIT1_I, ADDR_SELECT_BIT0_I};
			asel_s2_q <= asel_s1_q;
		end
	end

	// =====================================================================
	// Serial slave.
	logic [7:0] i2c_ptr, i2c_wdata;
	logic i2c_wr, i2c_first, i2c_rd;
	logic [15:0] i2c_rdata;

	// The slave never drives the clock line, it only samples it.
	tsa_i2c_slave u_i2c (
		.clk_i(REF_CLK_I),
		.rst_n_i(RSTN_I),
		.scl_i(scl_s_q[1]),
		.sda_i(sda_s_q[1]),
		.addr_sel_i(asel_s2_q),
		.sda_oe_n_o(SDA_OE_N_O),
		.ptr_o(i2c_ptr),
		.wr_o(i2c_wr),
		.wdata_o(i2c_wdata),
		.wr_first_o(i2c_first),
		.rd_o(i2c_rd),
		.rdata_i(i2c_rdata)
	);
	assign SDA_O = 1'b0;

	// =====================================================================
	// Configuration and limit registers.
	logic [7:0] cfg_q, cfg_d;
	logic [15:0] otl_q, otl_d, hyl_q, hyl_d, temp_q, temp_d;
	logic [TSA_ST_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic [31:0] rdata_q, rdata_d;
	logic sd, int_mode, alarm_polarity;
	logic [1:0] fq;
	tsa_res_t res;

	assign sd = cfg_q[TSA_CFG_SD_POS];
	assign int_mode = cfg_q[TSA_CFG_INT_POS];
	assign alarm_polarity = cfg_q[TSA_CFG_POL_POS];
	assign fq = cfg_q[TSA_CFG_FQ_POS +: 2];
	assign res = tsa_res_t'(cfg_q[TSA_CFG_RES_POS +: 2]);

	// Serial pointer 0..3 selects result, config, over limit, hysteresis.
	always_comb begin
		case (i2c_ptr[1:0])
			2'h0: i2c_rdata = temp_q;
			2'h1: i2c_rdata = {cfg_q, cfg_q};
			2'h2: i2c_rdata = otl_q;
			default: i2c_rdata = hyl_q;
		endcase
	end

	always_comb begin
		cfg_d = cfg_q;
		otl_d = otl_q;
		hyl_d = hyl_q;
		mask_d = mask_q;
		rdata_d = 32'h0000_0000;
		if (WR_I) begin
			if (ADDR_I == TSA_CFG_OFS) begin
				cfg_d = WDATA_I[7:0];
			end else if (ADDR_I == TSA_OTL_OFS) begin
				otl_d = WDATA_I[15:0];
			end else if (ADDR_I == TSA_HYL_OFS) begin
				hyl_d = WDATA_I[15:0];
			end else if (ADDR_I == TSA_MASK_OFS) begin
				mask_d = WDATA_I[TSA_ST_W-1:0];
			end
		end
		if (i2c_wr) begin
			case (i2c_ptr[1:0])
				2'h1: cfg_d = i2c_wdata;
				2'h2: otl_d = i2c_first ? {i2c_wdata, otl_q[7:0]} : {otl_q[15:8], i2c_wdata};
				2'h3: hyl_d = i2c_first ? {i2c_wdata, hyl_q[7:0]} : {hyl_q[15:8], i2c_wdata};
				default: cfg_d = cfg_q;
			endcase
		end
		if (RD_I) begin
			if (ADDR_I == TSA_TEMP_OFS) begin
				rdata_d = {16'h0000, temp_q};
			end else if (ADDR_I == TSA_CFG_OFS) begin
				rdata_d = {24'h000000, cfg_q};
			end else if (ADDR_I == TSA_OTL_OFS) begin
				rdata_d = {16'h0000, otl_q};
			end else if (ADDR_I == TSA_HYL_OFS) begin
				rdata_d = {16'h0000, hyl_q};
			end else if (ADDR_I == TSA_STAT_OFS) begin
				rdata_d = {30'h0, stat_q};
			end else if (ADDR_I == TSA_MASK_OFS) begin
				rdata_d = {30'h0, mask_q};
			end else if (ADDR_I == TSA_SENS_OFS) begin
				rdata_d = {20'h00000, SENSE_CODE_I};
			end
		end
	end

	// =====================================================================
	// Conversion timing. Each step to a finer resolution doubles the conversion time.
	logic [31:0] conv_cnt_q, conv_cnt_d, conv_len;
	logic conv_done, conv_run_q, conv_run_d;

	always_comb begin
		case (res)
			TSA_RES_9: conv_len = 32'(CONV_CYCLES);
			TSA_RES_10: conv_len = 32'(CONV_CYCLES) << 1;
			TSA_RES_11: conv_len = 32'(CONV_CYCLES) << 2;
			default: conv_len = 32'(CONV_CYCLES) << 3;
		endcase
	end

	// A conversion in progress finishes before standby takes hold.
	always_comb begin
		conv_cnt_d = conv_cnt_q;
		conv_run_d = conv_run_q;
		conv_done = 1'b0;
		if (conv_run_q) begin
			if (conv_cnt_q + 32'h1 >= conv_len) begin
				conv_done = 1'b1;
				conv_cnt_d = 32'h0;
				conv_run_d = !sd;
			end else begin
				conv_cnt_d = conv_cnt_q + 32'h1;
			end
		end else if (!sd) begin
			conv_run_d = 1'b1;
		end
	end

	always_comb begin
		temp_d = temp_q;
		if (conv_done) begin
			case (res)
				TSA_RES_9: temp_d = {SENSE_CODE_I[11:3], 7'h00};
				TSA_RES_10: temp_d = {SENSE_CODE_I[11:2], 6'h00};
				TSA_RES_11: temp_d = {SENSE_CODE_I[11:1], 5'h00};
				default: temp_d = {SENSE_CODE_I, 4'h0};
			endcase
		end
	end

	// =====================================================================
	// Alarm with fault queue.
	logic [15:0] cmp_mask;
	logic [2:0] fq_need, flt_cnt_q, flt_cnt_d;
	logic alm_q, alm_d, arm_q, arm_d, over, under, fault;

	always_comb begin
		case (res)
			TSA_RES_9: cmp_mask = 16'hff80;
			TSA_RES_10: cmp_mask = 16'hffc0;
			TSA_RES_11: cmp_mask = 16'hffe0;
			default: cmp_mask = 16'hfff0;
		endcase
		case (fq)
			2'h0: fq_need = 3'h1;
			2'h1: fq_need = 3'h2;
			2'h2: fq_need = 3'h4;
			default: fq_need = 3'h6;
		endcase
	end

	assign over = $signed(temp_d & cmp_mask) > $signed(otl_q & cmp_mask);
	assign under = $signed(temp_d & cmp_mask) < $signed(hyl_q & cmp_mask);
	// In interrupt mode a cleared alarm re-arms on the opposite crossing, so the
	// crossing direction is kept apart from the alarm itself, which a read clears.
	assign fault = (int_mode && arm_q) ? under : over;

	always_comb begin
		flt_cnt_d = flt_cnt_q;
		alm_d = alm_q;
		arm_d = int_mode ? arm_q : 1'b0;
		if (conv_done) begin
			if (!int_mode) begin
				if (over) begin
					flt_cnt_d = (flt_cnt_q < 3'h6) ? flt_cnt_q + 3'h1 : flt_cnt_q;
					if (flt_cnt_q + 3'h1 >= fq_need) alm_d = 1'b1;
				end else begin
					flt_cnt_d = 3'h0;
					if (under) alm_d = 1'b0;
				end
			end else if (fault) begin
				flt_cnt_d = (flt_cnt_q < 3'h6) ? flt_cnt_q + 3'h1 : flt_cnt_q;
				if (flt_cnt_q + 3'h1 >= fq_need) begin
					alm_d = 1'b1;
					arm_d = !arm_q;
					flt_cnt_d = 3'h0;
				end
			end else begin
				flt_cnt_d = 3'h0;
			end
		end
		if (int_mode && (sd || i2c_rd || RD_I)) alm_d = 1'b0;
	end

	// =====================================================================
	// Interrupt status, set wins over a write-one clear.
	assign ev[TSA_ST_CONV_POS] = conv_done;
	assign ev[TSA_ST_ALM_POS] = alm_d && !alm_q;
	always_comb begin
		stat_d = stat_q;
		if (WR_I && ADDR_I == TSA_STAT_OFS) stat_d = stat_q & ~WDATA_I[TSA_ST_W-1:0];
		stat_d = stat_d | ev;
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			cfg_q <= TSA_CFG_RST;
			otl_q <= TSA_OTL_RST;
			hyl_q <= TSA_HYL_RST;
			temp_q <= TSA_TEMP_RST;
			mask_q <= '0;
			stat_q <= '0;
			rdata_q <= 32'h0000_0000;
			conv_cnt_q <= 32'h0;
			conv_run_q <= 1'b0;
			flt_cnt_q <= 3'h0;
			alm_q <= 1'b0;
			arm_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			otl_q <= otl_d;
			hyl_q <= hyl_d;
			temp_q <= temp_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			rdata_q <= rdata_d;
			conv_cnt_q <= conv_cnt_d;
			conv_run_q <= conv_run_d;
			flt_cnt_q <= flt_cnt_d;
			alm_q <= alm_d;
			arm_q <= arm_d;
		end
	end

	// Polarity zero makes the pin pull low when the alarm is active.
	assign THERMAL_ALARM_OUT_O = 1'b0;
	assign THERMAL_ALARM_OUT_OE_N_O = alarm_polarity ? alm_q : !alm_q;
	assign RDATA_O = rdata_q;
	assign IRQ_O = |(stat_q & mask_q);

endmodule

// File: verification/tsa_core_assertions.sv
// Checker for the alarm core, watching only the top ports.
// Assumes it is bound into tsa_core and the bench keeps to one bus strobe a cycle.
`timescale 1ns/100ps
module tsa_core_assertions
	import tsa_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	input wire logic SCL_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_N_O,
	input wire logic THERMAL_ALARM_OUT_O,
	input wire logic THERMAL_ALARM_OUT_OE_N_O,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic IRQ_O
);
	// ====
	// Properties
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);
	a_sda_pull_only: assert property (SDA_O == 1'b0)
		else $error("data pin driven high");
	a_alarm_pull_only: assert property (THERMAL_ALARM_OUT_O == 1'b0)
		else $error("alarm pin driven high");
	a_rdata_idle_zero: assert property (!RD_I |=> RDATA_O == 32'h0)
		else $error("read data outside read slot");
	a_unmapped_reads_zero: assert property (RD_I && ADDR_I == 8'h1c |=> RDATA_O == 32'h0)
		else $error("unmapped read not zero");
	a_temp_low_bits: assert property (RD_I && ADDR_I == TSA_TEMP_OFS |=> RDATA_O[3:0] == 4'h0)
		else $error("result low bits not zero");
	a_cfg_read_back: assert property (WR_I && ADDR_I == TSA_CFG_OFS ##1
		RD_I && ADDR_I == TSA_CFG_OFS |=> RDATA_O[7:0] == $past(WDATA_I[7:0], 2))
		else $error("config read back differs");
	a_limit_read_back: assert property (WR_I && ADDR_I == TSA_OTL_OFS ##1
		RD_I && ADDR_I == TSA_OTL_OFS |=> RDATA_O[15:0] == $past(WDATA_I[15:0], 2))
		else $error("limit read back differs");
	a_sda_steady_scl_high: assert property (SCL_I [*4] |-> $stable(SDA_OE_N_O))
		else $error("data changed while clock high");
	a_reset_alarm_idle: assert property ($rose(RSTN_I) |-> THERMAL_ALARM_OUT_OE_N_O && !IRQ_O)
		else $error("alarm or irq active after reset");
	c_alarm_on: cover property ($fell(THERMAL_ALARM_OUT_OE_N_O));
	c_irq_on: cover property ($rose(IRQ_O));
	c_slave_ack: cover property ($fell(SDA_OE_N_O));
endmodule

bind tsa_core tsa_core_assertions u_tsa_core_assertions (.REF_CLK_I, .RSTN_I, .SCL_I, .SDA_O,
	.SDA_OE_N_O, .THERMAL_ALARM_OUT_O, .THERMAL_ALARM_OUT_OE_N_O, .ADDR_I, .WDATA_I, .WR_I,
	.RD_I, .RDATA_O, .IRQ_O);

// File: verification/tsa_i2c_mst.sv
// Behavioural serial bus master facing the core's data and clock pins.
// Assumes the bench forms the wired level of SDA with a pull-up.
`timescale 1ns/100ps
module tsa_i2c_mst #(
	parameter int HALF_CYC = 10
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_n_o
);
	// ====
	// Bus phases
	// Data moves a quarter phase after the clock falls, so it never races the clock edge.
	// Pins change only by non-blocking assignment just after a reference clock edge.
	initial begin
		scl_o <= 1'b1;
		sda_oe_n_o <= 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic xbit(input logic b, output logic r);
		tick(HALF_CYC / 4);
		sda_oe_n_o <= b;
		tick(HALF_CYC - HALF_CYC / 4);
		scl_o <= 1'b1;
		tick(HALF_CYC / 2);
		r = sda_i;
		tick(HALF_CYC - HALF_CYC / 2);
		scl_o <= 1'b0;
	endtask
	task automatic start;
		tick(HALF_CYC / 4);
		sda_oe_n_o <= 1'b1;
		tick(HALF_CYC - HALF_CYC / 4);
		scl_o <= 1'b1;
		tick(HALF_CYC / 2);
		sda_oe_n_o <= 1'b0;
		tick(HALF_CYC - HALF_CYC / 2);
		scl_o <= 1'b0;
	endtask
	task automatic stop;
		tick(HALF_CYC / 4);
		sda_oe_n_o <= 1'b0;
		tick(HALF_CYC - HALF_CYC / 4);
		scl_o <= 1'b1;
		tick(HALF_CYC / 2);
		sda_oe_n_o <= 1'b1;
		tick(HALF_CYC - HALF_CYC / 2);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(d[i], r);
		xbit(1'b1, ack);
	endtask
	task automatic rbyte(output logic [7:0] d, input logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
		xbit(nack, r);
	endtask
endmodule

// File: verification/tsa_core_tb.sv
// Self-checking bench for the alarm core with a short conversion count.
// Assumes the serial master model and the bound checker are compiled with it.
`timescale 1ns/100ps
module tsa_core_tb;
	import tsa_pkg::*;
	// ====
	// Stimulus and checks
	localparam int CONV = 50;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] addr_sel = 3'h5;
	logic [11:0] sense = 12'h19a;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic scl, m_oe_n, sda_oe_n, alm_oe_n, irq;
	logic [31:0] rdata;
	wire sda_w = m_oe_n & sda_oe_n;
	int err_count = 0;
	int total_checks = 0;
	always #4 clk = ~clk;
	tsa_core #(.CONV_CYCLES(CONV)) u_tsa_core (.REF_CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl),
		.SDA_I(sda_w), .SDA_O(), .SDA_OE_N_O(sda_oe_n), .ADDR_SELECT_BIT0_I(addr_sel[0]),
		.ADDR_SELECT_BIT1_I(addr_sel[1]), .ADDR_SELECT_BIT2_I(addr_sel[2]),
		.THERMAL_ALARM_OUT_O(), .THERMAL_ALARM_OUT_OE_N_O(alm_oe_n), .SENSE_CODE_I(sense),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq));
	tsa_i2c_mst u_tsa_i2c_mst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(m_oe_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		bus(1'b0, 1'b1, a, 32'h0);
		bus(1'b0, 1'b0, a, 32'h0);
		#1 chk(rdata, e, m);
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask
	task automatic put(input logic [11:0] v);
		@(posedge clk);
		sense <= v;
	endtask
	task automatic t_reset;
		chk(alm_oe_n, 1'b1, "alarm idle");
		rdc(TSA_CFG_OFS, 32'h0, "cfg reset");
		rdc(TSA_OTL_OFS, 32'(TSA_OTL_RST), "over reset");
		rdc(TSA_HYL_OFS, 32'(TSA_HYL_RST), "hys reset");
		rdc(8'h1c, 32'h0, "unmapped");
		cyc(CONV + 10);
		rdc(TSA_TEMP_OFS, 32'h1980, "first result");
		$display("test reset done");
	endtask
	task automatic t_res;
		logic [15:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 16'hfff0 << (3 - i);
			bus(1'b1, 1'b0, TSA_CFG_OFS, 32'(i << TSA_CFG_RES_POS));
			rdc(TSA_CFG_OFS, 32'(i << TSA_CFG_RES_POS), "cfg back");
			cyc(2 * (CONV << i) + 10);
			rdc(TSA_TEMP_OFS, {16'h0, 16'h19a0 & m}, "resolution");
		end
		wrr(TSA_CFG_OFS, 32'h0);
		cyc(8 * CONV);
		$display("test resolution done");
	endtask
	task automatic t_cmp;
		int n;
		bus(1'b1, 1'b0, TSA_OTL_OFS, 32'h1900);
		rdc(TSA_OTL_OFS, 32'h1900, "over back");
		wrr(TSA_HYL_OFS, 32'h1800);
		for (int q = 0; q < 4; q++) begin
			n = (q == 0) ? 1 : 2 * q;
			wrr(TSA_CFG_OFS, 32'(q << TSA_CFG_FQ_POS));
			put(12'h170);
			cyc(8 * CONV);
			chk(alm_oe_n, 1'b1, "alarm off");
			put(12'h1a0);
			if (n > 1) begin
				cyc((n - 1) * CONV - 10);
				chk(alm_oe_n, 1'b1, "early alarm");
			end
			cyc(2 * CONV + 10);
			chk(alm_oe_n, 1'b0, "alarm on");
		end
		put(12'h188);
		cyc(8 * CONV);
		chk(alm_oe_n, 1'b0, "hold above hys");
		wrr(TSA_CFG_OFS, 32'h19);
		cyc(CONV + 5);
		put(12'h170);
		cyc(3 * CONV);
		chk(alm_oe_n, 1'b0, "hold in standby");
		wrr(TSA_CFG_OFS, 32'h04);
		cyc(8 * CONV);
		chk(alm_oe_n, 1'b0, "inactive high pol");
		wrr(TSA_CFG_OFS, 32'h0);
		cyc(2);
		chk(alm_oe_n, 1'b1, "inactive low pol");
		$display("test comparator done");
	endtask
	task automatic t_int;
		wrr(TSA_MASK_OFS, 32'h0);
		wrr(TSA_STAT_OFS, 32'h3);
		wrr(TSA_CFG_OFS, 32'h2);
		put(12'h1a0);
		cyc(3 * CONV);
		chk(alm_oe_n, 1'b0, "int alarm");
		chk(irq, 1'b0, "irq masked");
		wrr(TSA_MASK_OFS, 32'h2);
		cyc(2);
		chk(irq, 1'b1, "irq on");
		rdc(TSA_HYL_OFS, 32'h1800, "hys");
		cyc(2);
		chk(alm_oe_n, 1'b1, "read clears");
		cyc(3 * CONV);
		chk(alm_oe_n, 1'b1, "no rearm high");
		put(12'h170);
		cyc(3 * CONV);
		chk(alm_oe_n, 1'b0, "low crossing");
		wrr(TSA_CFG_OFS, 32'h3);
		cyc(2);
		chk(alm_oe_n, 1'b1, "standby clears");
		cyc(2 * CONV);
		wrr(TSA_STAT_OFS, 32'h2);
		cyc(2);
		chk(irq, 1'b0, "status cleared");
		wrr(TSA_CFG_OFS, 32'h0);
		$display("test interrupt done");
	endtask
	task automatic t_i2c;
		logic a;
		logic [7:0] b;
		for (int s = 0; s < 8; s++) begin
			@(posedge clk);
			addr_sel <= 3'(s);
			cyc(4);
			u_tsa_i2c_mst.start();
			u_tsa_i2c_mst.wbyte(8'h9a, a);
			u_tsa_i2c_mst.stop();
			chk(a, (s == 5) ? 1'b0 : 1'b1, "address ack");
		end
		@(posedge clk);
		addr_sel <= 3'h5;
		cyc(4);
		u_tsa_i2c_mst.start();
		u_tsa_i2c_mst.wbyte(8'h9a, a);
		u_tsa_i2c_mst.wbyte(8'h01, a);
		u_tsa_i2c_mst.wbyte(8'h60, a);
		u_tsa_i2c_mst.stop();
		chk(a, 1'b0, "data ack");
		rdc(TSA_CFG_OFS, 32'h60, "serial write");
		u_tsa_i2c_mst.start();
		u_tsa_i2c_mst.wbyte(8'h9a, a);
		u_tsa_i2c_mst.wbyte(8'h02, a);
		u_tsa_i2c_mst.wbyte(8'h1a, a);
		u_tsa_i2c_mst.wbyte(8'h80, a);
		u_tsa_i2c_mst.stop();
		rdc(TSA_OTL_OFS, 32'h1a80, "serial limit");
		u_tsa_i2c_mst.start();
		u_tsa_i2c_mst.wbyte(8'h9a, a);
		u_tsa_i2c_mst.wbyte(8'h01, a);
		u_tsa_i2c_mst.start();
		u_tsa_i2c_mst.wbyte(8'h9b, a);
		u_tsa_i2c_mst.rbyte(b, 1'b1);
		u_tsa_i2c_mst.stop();
		chk(b, 8'h60, "serial read");
		$display("test serial done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		finish_test();
	end
	initial begin
		cyc(20);
		rstn <= 1'b1;
		t_reset();
		t_res();
		t_cmp();
		t_int();
		t_i2c();
		finish_test();
	end
endmodule
